// *** core/lcd_cascade_pkg.sv ***
package lcd_cascade_pkg;

  // byte slot on the link: marker bit, eight data bits msb first, ack bit
  localparam logic [3:0] BIT_MARKER    = 4'h0;
  localparam logic [3:0] BIT_LAST_DATA = 4'h8;
  localparam logic [3:0] BIT_ACK       = 4'h9;

  // last display ram addresses of the two pointer variants
  localparam int RAM_LAST_7BIT = 79;
  localparam int RAM_LAST_SPLIT = 159;

  // upper six bits of the shared bus address (arbitrary value)
  localparam logic [5:0] ADDR_UPPER_DEF = 6'h15;

  // control byte fields
  localparam int CTRL_CONT_BIT = 7;
  localparam int CTRL_RS_BIT   = 6;

  // command encodings
  localparam logic [3:0] NIB_LSB_PFX = 4'h4;
  localparam logic [3:0] NIB_MSB_PFX = 4'h0;
  localparam logic [4:0] PICK_PFX    = 5'h1c;

  // control and command bytes the master emits
  localparam logic [7:0] CTRL_CMD_MORE  = 8'h80;
  localparam logic [7:0] CTRL_DATA_LAST = 8'h40;
  localparam logic [7:0] CMD_LSB_ZERO   = 8'h40;
  localparam logic [7:0] CMD_MSB_ZERO   = 8'h00;

  // master register map
  localparam logic [7:0] REG_OP     = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int OP_LSB  = 0;
  localparam int ARG_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_ACK  = 1;
  localparam int ST_NACK = 2;

  // master operations
  localparam logic [2:0] OP_START      = 3'h0;
  localparam logic [2:0] OP_CMD        = 3'h1;
  localparam logic [2:0] OP_PTR        = 3'h2;
  localparam logic [2:0] OP_PICK       = 3'h3;
  localparam logic [2:0] OP_DATA_BEGIN = 3'h4;
  localparam logic [2:0] OP_DATA       = 3'h5;
  localparam logic [2:0] OP_STOP       = 3'h6;

  // link clock timing
  localparam int MCLK_MHZ    = 100;
  localparam int SCL_HALF_NS = 1250;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * MCLK_MHZ + 999) / 1000;

endpackage

// *** core/link_if.sv ***
`timescale 1ns/1ps
interface link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // open-drain wire with pull-up
  assign sda = ((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o))
               ? 1'b0 : 1'b1;

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input  sda
  );

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );
endinterface

// *** core/lcd_bus_master.sv ***
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
module lcd_bus_master #(
  parameter int HALF_CYC = lcd_cascade_pkg::SCL_HALF_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // link
  link_if.host             link
);
  import lcd_cascade_pkg::*;

  if (HALF_CYC < 4 || HALF_CYC > 65535) begin : g_bad_half
    $error("HALF_CYC out of range");
  end

  localparam logic [15:0] HALF_LOAD = 16'(HALF_CYC - 1);

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} hstate_t;

  typedef struct packed {
    hstate_t         st;
    logic [15:0]     cnt;
    logic [3:0]      bitpos;
    logic [5:0][7:0] q;
    logic [2:0]      qn;
    logic [2:0]      qi;
    logic            stop;
    logic            scl;
    logic            sda_oe;
    logic            ack;
    logic            nack;
    logic [31:0]     rdata;
    logic [1:0]      sda_sync;
  } host_state_t;

  host_state_t r_reg;
  host_state_t r_next;
  logic        busy;
  logic [2:0]  op;
  logic [7:0]  arg;
  logic [7:0]  cur;
  logic [3:0]  nb;

  assign busy = (r_reg.st != H_IDLE) || (r_reg.qn != 3'h0) || r_reg.stop;
  assign op   = wdata[OP_LSB +: 3];
  assign arg  = wdata[ARG_LSB +: 8];
  assign cur  = r_reg.q[r_reg.qi];
  assign nb   = r_reg.bitpos + 4'h1;

  always_comb begin
    r_next = r_reg;
    r_next.sda_sync = {r_reg.sda_sync[0], link.sda};
    r_next.rdata = 32'h0;
    if (rd) begin
      if (addr == REG_STATUS) begin
        r_next.rdata[ST_BUSY] = busy;
        r_next.rdata[ST_ACK]  = r_reg.ack;
        r_next.rdata[ST_NACK] = r_reg.nack;
      end
    end
    // operations arriving while busy are dropped
    if (wr && addr == REG_OP && !busy) begin
      r_next.qi   = 3'h0;
      r_next.nack = 1'b0;
      case (op)
        OP_START: begin
          r_next.q[0] = arg;
          r_next.qn   = 3'h1;
        end
        OP_CMD: begin
          r_next.q[0] = CTRL_CMD_MORE;
          r_next.q[1] = arg;
          r_next.qn   = 3'h2;
        end
        OP_PTR: begin
          r_next.q[0] = CTRL_CMD_MORE;
          r_next.q[1] = {NIB_LSB_PFX, arg[3:0]};
          r_next.q[2] = CTRL_CMD_MORE;
          r_next.q[3] = {NIB_MSB_PFX, arg[7:4]};
          r_next.qn   = 3'h4;
        end
        OP_PICK: begin
          r_next.q[0] = CTRL_CMD_MORE;
          r_next.q[1] = {PICK_PFX, arg[2:0]};
          r_next.q[2] = CTRL_CMD_MORE;
          r_next.q[3] = CMD_LSB_ZERO;
          r_next.q[4] = CTRL_CMD_MORE;
          r_next.q[5] = CMD_MSB_ZERO;
          r_next.qn   = 3'h6;
        end
        OP_DATA_BEGIN: begin
          r_next.q[0] = CTRL_DATA_LAST;
          r_next.qn   = 3'h1;
        end
        OP_DATA: begin
          r_next.q[0] = arg;
          r_next.qn   = 3'h1;
        end
        OP_STOP: r_next.stop = 1'b1;
        default: r_next.qn = 3'h0;
      endcase
    end
    case (r_reg.st)
      H_IDLE: begin
        if (r_reg.qn != 3'h0 || r_reg.stop) begin
          r_next.st     = H_LOW;
          r_next.cnt    = HALF_LOAD;
          r_next.bitpos = BIT_MARKER;
          r_next.scl    = 1'b0;
          // marker low opens a byte slot, marker high ends the frame
          r_next.sda_oe = (r_reg.qn != 3'h0);
        end
      end
      H_LOW: begin
        if (r_reg.cnt == 16'h0) begin
          r_next.st  = H_HIGH;
          r_next.cnt = HALF_LOAD;
          r_next.scl = 1'b1;
          if (r_reg.bitpos == BIT_ACK) begin
            r_next.ack = !r_reg.sda_sync[1];
            if (r_reg.sda_sync[1]) begin
              r_next.nack = 1'b1;
            end
          end
        end else begin
          r_next.cnt = r_reg.cnt - 16'h1;
        end
      end
      default: begin
        if (r_reg.cnt == 16'h0) begin
          r_next.scl = 1'b0;
          if (r_reg.qn == 3'h0) begin
            r_next.stop   = 1'b0;
            r_next.sda_oe = 1'b0;
            r_next.st     = H_IDLE;
          end else if (r_reg.bitpos == BIT_ACK) begin
            r_next.qn = r_reg.qn - 3'h1;
            r_next.qi = r_reg.qi + 3'h1;
            r_next.st = H_IDLE;
          end else begin
            r_next.bitpos = nb;
            r_next.st     = H_LOW;
            r_next.cnt    = HALF_LOAD;
            if (nb <= BIT_LAST_DATA) begin
              r_next.sda_oe = !cur[3'(BIT_LAST_DATA - nb)];
            end else begin
              r_next.sda_oe = 1'b0;
            end
          end
        end else begin
          r_next.cnt = r_reg.cnt - 16'h1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata            = r_reg.rdata;
  assign link.scl         = r_reg.scl;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = r_reg.sda_oe;
endmodule

// *** core/lcd_cascade_driver.sv ***
`timescale 1ns/1ps
// What this block does
// - pointer command has msb zero, seven-bit address
// - continuation bit travels in separate control byte
// - acknowledge address when select pin matches bit
// - control byte: continuation b7, register select b6, rest ignored
// - master puts control byte between commands
// - seven-bit variant accepts addresses 0 to 79
// - split variant loads upper, lower nibble separately
// - master sends both nibble commands
// - master picks driver then reloads pointer
// - every driver advances pointer on each write
// - subaddress pins held stable during transfers
// - master sends lower nibble command first
// - pointer wraps to zero, subaddress counter increments
// - store only when counter equals subaddress pins
// - pick command loads the subaddress counter
// - continuation one means a control byte follows the next byte
// - last driver discards overflow without acknowledge
module lcd_cascade_driver #(
  parameter logic       SPLIT_PTR  = 1'b0,
  parameter int         RAM_LAST   = lcd_cascade_pkg::RAM_LAST_7BIT,
  parameter logic [5:0] ADDR_UPPER = lcd_cascade_pkg::ADDR_UPPER_DEF
) (
  // link
  link_if.dev              link,
  // reset
  input  wire logic        resetn,
  // strap pins
  input  wire logic        slave_addr_select_pin,
  input  wire logic        hw_subaddr_pin_bit0,
  input  wire logic        hw_subaddr_pin_bit1,
  input  wire logic        hw_subaddr_pin_bit2,
  // display ram store port
  output logic             store_we,
  output logic [7:0]       store_addr,
  output logic [7:0]       store_data,
  // status
  output logic [7:0]       data_ptr,
  output logic [2:0]       subaddr_count
);
  import lcd_cascade_pkg::*;

  if (RAM_LAST < 1 || RAM_LAST > 255) begin : g_bad_last
    $error("RAM_LAST out of range");
  end
  if (!SPLIT_PTR && RAM_LAST > 127) begin : g_bad_variant
    $error("seven-bit pointer cannot reach RAM_LAST");
  end

  localparam logic [7:0] LAST = 8'(RAM_LAST);

  typedef enum logic [2:0] {
    D_IDLE,
    D_ADDR,
    D_CTRL,
    D_CMD,
    D_DATA,
    D_SKIP
  } dstate_t;

  typedef struct packed {
    dstate_t         st;
    logic [3:0]      bitpos;
    logic [6:0]      shift;
    logic            cont;
    logic [7:0]      ptr;
    logic [2:0]      subcnt;
    logic            sda_oe;
    logic            we;
    logic [7:0]      waddr;
    logic [7:0]      wdata;
    logic [1:0]      sa_sync;
    logic [1:0][2:0] hw_sync;
  } dev_state_t;

  dev_state_t r_reg;
  dev_state_t r_next;
  logic [7:0] rx_byte;
  logic [2:0] hw_sub;
  logic [2:0] sub_after;
  logic [7:0] ptr_after;
  logic       at_end;

  // sda needs no synchroniser: the master moves it only while scl is low
  assign rx_byte = {r_reg.shift, link.sda};
  assign hw_sub  = r_reg.hw_sync[1];
  assign at_end  = (r_reg.ptr >= LAST);

  assign ptr_after = at_end ? 8'h0 : r_reg.ptr + 8'h1;
  assign sub_after = at_end ? r_reg.subcnt + 3'h1 : r_reg.subcnt;

  always_comb begin
    r_next = r_reg;
    r_next.we = 1'b0;
    // strap pins settle through two stages before use
    r_next.sa_sync    = {r_reg.sa_sync[0], slave_addr_select_pin};
    r_next.hw_sync[0] = {hw_subaddr_pin_bit2, hw_subaddr_pin_bit1,
                         hw_subaddr_pin_bit0};
    r_next.hw_sync[1] = r_reg.hw_sync[0];
    case (r_reg.st)
      D_IDLE: begin
        r_next.sda_oe = 1'b0;
        // a low marker on a quiet link opens a frame
        if (!link.sda) begin
          r_next.st     = D_ADDR;
          r_next.bitpos = 4'h1;
        end
      end
      default: begin
        if (r_reg.bitpos == BIT_MARKER) begin
          // a high marker closes the frame
          if (link.sda) begin
            r_next.st = D_IDLE;
          end else begin
            r_next.bitpos = 4'h1;
          end
        end else if (r_reg.bitpos < BIT_LAST_DATA) begin
          r_next.shift  = {r_reg.shift[5:0], link.sda};
          r_next.bitpos = r_reg.bitpos + 4'h1;
        end else if (r_reg.bitpos == BIT_LAST_DATA) begin
          // the ack is pulled from this edge until the next one
          r_next.bitpos = BIT_ACK;
          case (r_reg.st)
            D_ADDR: begin
              // match select pin on address bit 1
              if (rx_byte[7:2] == ADDR_UPPER &&
                  rx_byte[1] == r_reg.sa_sync[1] && !rx_byte[0]) begin
                r_next.st     = D_CTRL;
                r_next.sda_oe = 1'b1;
              end else begin
                // foreign address: sit out the rest of the frame
                r_next.st = D_SKIP;
              end
            end
            D_CTRL: begin
              r_next.cont   = rx_byte[CTRL_CONT_BIT];
              r_next.st     = rx_byte[CTRL_RS_BIT] ? D_DATA : D_CMD;
              r_next.sda_oe = 1'b1;
            end
            D_CMD: begin
              // every command byte is acked, known or not
              r_next.sda_oe = 1'b1;
              r_next.st = r_reg.cont ? D_CTRL : D_CMD;
              if (!SPLIT_PTR && !rx_byte[7]) begin
                if ({1'b0, rx_byte[6:0]} <= LAST) begin
                  r_next.ptr = {1'b0, rx_byte[6:0]};
                end
              end else if (SPLIT_PTR && rx_byte[7:4] == NIB_LSB_PFX) begin
                r_next.ptr[3:0] = rx_byte[3:0];
              end else if (SPLIT_PTR && rx_byte[7:4] == NIB_MSB_PFX) begin
                r_next.ptr[7:4] = rx_byte[3:0];
              end else if (rx_byte[7:3] == PICK_PFX) begin
                r_next.subcnt = rx_byte[2:0];
              end
            end
            D_DATA: begin
              // continuation set: one data byte, then a control byte
              r_next.st = r_reg.cont ? D_CTRL : D_DATA;
              if (r_reg.subcnt == hw_sub) begin
                r_next.we    = 1'b1;
                r_next.waddr = r_reg.ptr;
                r_next.wdata = rx_byte;
              end
              r_next.ptr    = ptr_after;
              r_next.subcnt = sub_after;
              // ack only if the counter after this byte equals the pins, whether or not this byte was stored
              r_next.sda_oe = (sub_after == hw_sub);
            end
            default: r_next.sda_oe = 1'b0;
          endcase
        end else begin
          r_next.sda_oe = 1'b0;
          r_next.bitpos = BIT_MARKER;
        end
      end
    endcase
  end

  // runs on the link clock; reset reaches it without any clock edge
  always_ff @(posedge link.scl or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = r_reg.sda_oe;
  assign store_we        = r_reg.we;
  assign store_addr      = r_reg.waddr;
  assign store_data      = r_reg.wdata;
  assign data_ptr        = r_reg.ptr;
  assign subaddr_count   = r_reg.subcnt;
endmodule

// *** verif/lcd_cascade_assertions.sv ***
`timescale 1ns/1ps
module lcd_cascade_checker #(
  parameter logic [5:0] ADDR_UPPER = lcd_cascade_pkg::ADDR_UPPER_DEF,
  parameter logic       SEL        = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  import lcd_cascade_pkg::*;
  logic [3:0] bit_q;
  logic [1:0] byte_n;
  logic [7:0] shreg;
  logic       in_frame;
  logic       matched;
  logic       hit;

  assign hit = shreg[7:1] == {ADDR_UPPER, SEL};

  // rebuild byte slots from the wire
  always_ff @(posedge scl or negedge resetn) begin
    if (!resetn) begin
      bit_q    <= 4'h0;
      byte_n   <= 2'h0;
      shreg    <= 8'h00;
      in_frame <= 1'b0;
      matched  <= 1'b0;
    end else if (bit_q == 4'h0) begin
      bit_q    <= sda ? 4'h0 : 4'h1;
      byte_n   <= !in_frame ? 2'h0 : (byte_n == 2'h3 ? byte_n : byte_n + 2'h1);
      in_frame <= !sda;
    end else if (bit_q == 4'h9) begin
      bit_q <= 4'h0;
      if (byte_n == 2'h0) matched <= hit;
    end else begin
      bit_q <= bit_q + 4'h1;
      shreg <= {shreg[6:0], sda};
    end
  end

  chk_ack_slot_only: assert property (
    @(posedge scl) disable iff (!resetn) dev_sda_oe |-> bit_q == 4'h9)
    else $error("ack outside its slot");
  chk_ack_one_pulse: assert property (
    @(posedge scl) disable iff (!resetn) dev_sda_oe |=> !dev_sda_oe)
    else $error("ack held too long");
  chk_addr_ack_match: assert property (
    @(posedge scl) disable iff (!resetn)
    in_frame && bit_q == 4'h9 && byte_n == 2'h0 |-> dev_sda_oe == hit)
    else $error("address ack wrong");
  chk_ctrl_byte_ack: assert property (
    @(posedge scl) disable iff (!resetn)
    bit_q == 4'h9 && byte_n == 2'h1 && matched |-> dev_sda_oe)
    else $error("control byte not acked");
  chk_foreign_no_ack: assert property (
    @(posedge scl) disable iff (!resetn)
    byte_n != 2'h0 && !matched |-> !dev_sda_oe)
    else $error("ack for foreign address");
  chk_idle_quiet: assert property (
    @(posedge scl) disable iff (!resetn) !in_frame |-> !dev_sda_oe)
    else $error("device drives outside frame");
  chk_scl_high_len: assert property (
    @(posedge mclk) disable iff (!resetn)
    $rose(scl) |-> scl [*4] ##1 !scl)
    else $error("link clock high phase wrong");
  chk_sda_hold_high: assert property (
    @(posedge mclk) disable iff (!resetn)
    scl && $past(scl) |-> $stable(host_sda_oe))
    else $error("master data moved while clock high");

  cover property (@(posedge scl) disable iff (!resetn)
    bit_q == 4'h9 && byte_n == 2'h0 && dev_sda_oe);
  cover property (@(posedge scl) disable iff (!resetn)
    in_frame && bit_q == 4'h9 && byte_n == 2'h0 && !dev_sda_oe);
  cover property (@(posedge scl) disable iff (!resetn)
    bit_q == 4'h9 && byte_n == 2'h3 && dev_sda_oe);
endmodule

// *** verif/lcd_driver_cascade_command_addressing_bench.sv ***
`timescale 1ns/1ps
module lcd_driver_cascade_command_addressing_bench;
  import lcd_cascade_pkg::*;
  logic        mclk;
  logic        resetn;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        sel_a, sel_b, we_a, we_b;
  logic [2:0]  sub_a, sub_b, cnt_a, cnt_b;
  logic [7:0]  ptr_a, ptr_b, sa_a, sd_a, sa_b, sd_b;
  logic [31:0] st;
  logic [35:0] rows [11];
  int          errors, n_checks, cyc, na, nb, b_acks, b0, i;

  link_if link_a ();
  link_if link_b ();
  // second driver shares clock and master pulls
  assign link_b.scl         = link_a.scl;
  assign link_b.host_sda_o  = 1'b0;
  assign link_b.host_sda_oe = link_a.host_sda_oe;

  lcd_bus_master #(.HALF_CYC(4)) lcd_bus_master_inst (.mclk(mclk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link(link_a));
  lcd_cascade_driver #(.SPLIT_PTR(1'b1), .RAM_LAST(RAM_LAST_SPLIT))
    lcd_cascade_driver_inst (.link(link_a), .resetn(resetn),
    .slave_addr_select_pin(sel_a), .hw_subaddr_pin_bit0(sub_a[0]),
    .hw_subaddr_pin_bit1(sub_a[1]), .hw_subaddr_pin_bit2(sub_a[2]),
    .store_we(we_a), .store_addr(sa_a), .store_data(sd_a),
    .data_ptr(ptr_a), .subaddr_count(cnt_a));
  lcd_cascade_driver #(.SPLIT_PTR(1'b0), .RAM_LAST(RAM_LAST_7BIT))
    lcd_cascade_driver_inst_b (.link(link_b), .resetn(resetn),
    .slave_addr_select_pin(sel_b), .hw_subaddr_pin_bit0(sub_b[0]),
    .hw_subaddr_pin_bit1(sub_b[1]), .hw_subaddr_pin_bit2(sub_b[2]),
    .store_we(we_b), .store_addr(sa_b), .store_data(sd_b),
    .data_ptr(ptr_b), .subaddr_count(cnt_b));
  lcd_cascade_checker lcd_cascade_checker_inst (.mclk(mclk),
    .resetn(resetn), .scl(link_a.scl), .host_sda_oe(link_a.host_sda_oe),
    .dev_sda_oe(link_a.dev_sda_oe), .sda(link_a.sda));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  always @(posedge link_a.scl) begin
    if (we_a === 1'b1) na++;
    if (we_b === 1'b1) nb++;
    if (link_b.dev_sda_oe === 1'b1) b_acks++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one master operation, then poll until idle
  task automatic op(input logic [2:0] o, input logic [7:0] a);
    int n;
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= REG_OP;
    wdata <= {16'h0, a, 5'h0, o};
    @(posedge mclk);
    wr <= 1'b0;
    st = 32'h1;
    for (n = 0; n < 2000 && st[ST_BUSY] !== 1'b0; n++) begin
      @(posedge mclk);
      rd   <= 1'b1;
      addr <= REG_STATUS;
      @(posedge mclk);
      rd <= 1'b0;
      #1 st = rdata;
    end
    if (st[ST_BUSY] !== 1'b0) errors++;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    resetn = 1'b0;
    addr   = 8'h00;
    wdata  = 32'h0;
    wr     = 1'b0;
    rd     = 1'b0;
    sel_a  = 1'b0;
    sel_b  = 1'b0;
    sub_a  = 3'h0;
    sub_b  = 3'h2;
    // op, arg, ptr a, ptr b, count a, count b
    rows = '{36'h2_00_00_00_0_0, 36'h1_4f_0f_4f_0_0, 36'h1_50_0f_4f_0_0,
             36'h1_09_9f_09_0_0, 36'h2_4e_4e_04_0_0, 36'h3_02_00_00_2_2,
             36'h3_00_00_00_0_0, 36'h1_05_50_05_0_0, 36'h4_00_50_05_0_0,
             36'h5_a5_51_06_0_0, 36'h5_3c_52_07_0_0};
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk({we_a, we_b, rdata[5:0], ptr_a, ptr_b, 1'b0, cnt_a, 1'b0, cnt_b},
        32'h0);
    op(OP_START, {ADDR_UPPER_DEF, 1'b0, 1'b0});
    chk(st[2:1], 2'b01);
    for (i = 0; i < 11; i++) begin
      op(rows[i][34:32], rows[i][31:24]);
      chk({8'h0, ptr_a, ptr_b, 1'b0, cnt_a, 1'b0, cnt_b},
          {8'h0, rows[i][23:0]});
    end
    chk({sa_a, sd_a, na[7:0], nb[7:0]}, 32'h513c_0200);
    chk(st[2:1], 2'b01);
    // both drivers sit on their last address
    op(OP_STOP, 8'h00);
    op(OP_START, {ADDR_UPPER_DEF, 1'b0, 1'b0});
    op(OP_CMD, 8'h09);
    op(OP_CMD, 8'h4f);
    op(OP_DATA_BEGIN, 8'h00);
    op(OP_DATA, 8'h3c);
    chk({ptr_a, ptr_b, sa_a, 1'b0, cnt_a, 1'b0, cnt_b}, 32'h0000_9f11);
    chk({sd_a, na[7:0], st[2:1]}, {8'h3c, 8'h03, 2'b10});
    // foreign select bit: only the second driver answers
    op(OP_STOP, 8'h00);
    @(posedge mclk);
    sel_b <= 1'b1;
    b0 = b_acks;
    op(OP_START, {ADDR_UPPER_DEF, 1'b1, 1'b0});
    chk(b_acks - b0, 32'h1);
    chk(st[2:1], 2'b10);
    op(OP_CMD, 8'h05);
    chk({ptr_a, ptr_b}, 16'h0005);
    // second driver picked, reloaded and written
    op(OP_PICK, 8'h02);
    op(OP_DATA_BEGIN, 8'h00);
    op(OP_DATA, 8'h77);
    chk({sa_b, sd_b, nb[7:0], ptr_b}, 32'h0077_0101);
    op(OP_STOP, 8'h00);
    // reset in mid-run clears pointers and counters
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    #1;
    chk({we_a, we_b, ptr_a, ptr_b, 4'h0, cnt_a, 4'h0, cnt_b}, 32'h0);
    @(posedge mclk);
    resetn <= 1'b1;
    op(OP_START, {ADDR_UPPER_DEF, 1'b0, 1'b0});
    chk(st[2:1], 2'b01);
    op(OP_STOP, 8'h00);
    end_of_test();
  end
endmodule
